// File: logic/sram_ctl_regs.svh
/*
 Timing constants for the host-side controller of a 2k x 8 asynchronous
 battery-backed static memory. Assumes a 40 MHz system clock.
*/
`ifndef SRAM_CTL_REGS_SVH
`define SRAM_CTL_REGS_SVH

// Clock period in picoseconds (40 MHz)
`define CLK_PERIOD_PS 25000
// Array geometry
`define ADDR_W 11
`define DATA_W 8
// Timing figures in nanoseconds (protect recovery in ms), as printed
`define ACCESS_TIME_NS 100
`define WRITE_PULSE_NS 75
`define DATA_SETUP_TIME_NS 40
`define WRITE_RECOVERY_NS 10
`define PROTECT_RECOVERY_TIME_MS 125
// Cycle counts derived from the figures (least times round up)
`define ACCESS_CYC ((`ACCESS_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WRITE_PULSE_CYC ((`WRITE_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DATA_SETUP_CYC ((`DATA_SETUP_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RECOVERY_CYC ((`WRITE_RECOVERY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// 125 ms at 40 MHz; used as a parameter default since it is large
`define PROTECT_CYC (`PROTECT_RECOVERY_TIME_MS * 40000)
// Widths of the phase counter and the protection counter
`define PHASE_CNT_W 8
`define PROTECT_CNT_W 24

`endif

// File: logic/sram_ctl_pkg.sv
/*
 Types for the static memory controller: bus state machine encoding.
 Assumes sram_ctl_regs.svh is compiled alongside for the constants.
*/
package sram_ctl_pkg;

    // Bus sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_RD    = 6'h02,
        ST_WSET  = 6'h04,
        ST_WPULS = 6'h08,
        ST_WREC  = 6'h10,
        ST_HOLD  = 6'h20
    } bus_state_t;

endpackage

// File: logic/protect_guard.sv
/*
 Write-protect guard: tracks the supply-monitor flag and holds the bus
 off for the recovery time after the flag drops.
 Assumes protect_i is synchronous to sys_clk_i.
*/
`timescale 1ns/100ps
`include "sram_ctl_regs.svh"

module protect_guard #(
    parameter int unsigned PROTECT_CYCLES = `PROTECT_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic protect_i,
    output logic blocked_o
);

    // Whole state of the guard
    typedef struct packed {
        logic [`PROTECT_CNT_W-1:0] cnt;
        logic blocked;
    } guard_t;

    guard_t s_q;
    guard_t s_d;

    // Hold blocked while flag is up, then count out the recovery
    always_comb
    begin
        s_d = s_q;
        if (protect_i)
        begin
            // Restart the full wait every time the flag is seen
            s_d.blocked = 1'b1;
            s_d.cnt = PROTECT_CYCLES[`PROTECT_CNT_W-1:0];
        end
        else if (s_q.cnt != '0)
        begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
        else
        begin
            s_d.blocked = 1'b0;
        end
    end

    // Start blocked: the supply is not known good at reset
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q <= '{cnt: '0, blocked: 1'b1};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign blocked_o = s_q.blocked;

endmodule

// File: logic/sram_ctl.sv
/*
 Host-side controller for a 2k x 8 asynchronous battery-backed static
 memory. A user request port issues single byte reads and writes; the
 controller sequences address, chip select, write strobe, output enable
 and the byte-wide data pins with cycle-counted timing at 40 MHz.
 Assumes all inputs are synchronous to sys_clk_i and that the pad ring
 resolves data_io from the output enable.
*/
// What this block does
// - Address held stable through whole write
// - Strobe up at least ten ns before select rise
// - Output enable kept high during writes
// - Select and strobe overlap at least 75 ns
// - Write data set up 40 ns before end
`timescale 1ns/100ps
`include "sram_ctl_regs.svh"

module sram_ctl
    import sram_ctl_pkg::*;
#(
    parameter int unsigned PROTECT_CYCLES = `PROTECT_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // User request port
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [`ADDR_W-1:0] req_addr_i,
    input wire logic [`DATA_W-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [`DATA_W-1:0] rsp_rdata_o,
    output logic blocked_o,
    // Supply-monitor flag from the memory side
    input wire logic protect_i,
    // Memory pins, active-low controls
    output logic [`ADDR_W-1:0] addr_in_o,
    output logic chip_sel_n_o,
    output logic write_strobe_n_o,
    output logic out_en_n_o,
    input wire logic [`DATA_W-1:0] data_io_i,
    output logic [`DATA_W-1:0] data_io_o,
    output logic data_io_oe_o
);

    // Whole state of the sequencer; every pin output is a field here
    typedef struct packed {
        bus_state_t state;
        // Down counter shared by all timed phases
        logic [`PHASE_CNT_W-1:0] cnt;
        logic [`ADDR_W-1:0] addr;
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic [`DATA_W-1:0] dout;
        logic doe;
        logic ready;
        logic rsp_valid;
        logic [`DATA_W-1:0] rdata;
        logic blocked;
    } ctl_t;

    ctl_t s_q;
    ctl_t s_d;
    // Protection window from the guard
    logic guard_blocked;

    // Guard kept apart so its long counter can be shortened in test
    // Protection guard counts out the recovery after the flag drops
    protect_guard #(
        .PROTECT_CYCLES(PROTECT_CYCLES)
    ) u_guard (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .protect_i(protect_i),
        .blocked_o(guard_blocked)
    );

    // Read frame: select and enable low five cycles, sampled on the last
    // Write frame: select, then strobe low four cycles, strobe up first
    // Select rises a cycle after the strobe, giving a full recovery cycle
    // Data stays driven until select rises; costs bus time, buys hold margin
    // Protection gates only new requests; a frame in flight runs to its end
    // Next-state logic for the bus sequencer
    always_comb
    begin
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        s_d.blocked = guard_blocked;
        // Shared decrement; loads in the phases below override it
        if (s_d.cnt != '0)
        begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
        case (s_q.state)
            ST_IDLE:
            begin
                // A request is only looked at once ready has been shown
                // Ready only while the memory is out of protection
                s_d.ready = !guard_blocked;
                if (s_q.ready && req_valid_i && !guard_blocked)
                begin
                    s_d.ready = 1'b0;
                    s_d.addr = req_addr_i;
                    s_d.cs_n = 1'b0;
                    if (req_write_i)
                    begin
                        // Select first, strobe a cycle later so outputs stay off
                        s_d.oe_n = 1'b1;
                        s_d.dout = req_wdata_i;
                        s_d.doe = 1'b1;
                        s_d.state = ST_WSET;
                    end
                    else
                    begin
                        s_d.oe_n = 1'b0;
                        s_d.cnt = `PHASE_CNT_W'(`ACCESS_CYC);
                        s_d.state = ST_RD;
                    end
                end
            end
            ST_RD:
            begin
                // Counter was loaded with the access count on entry
                // Sample only once the access time has fully elapsed
                if (s_q.cnt == '0)
                begin
                    s_d.rdata = data_io_i;
                    s_d.rsp_valid = 1'b1;
                    s_d.cs_n = 1'b1;
                    s_d.oe_n = 1'b1;
                    s_d.state = ST_HOLD;
                end
            end
            ST_WSET:
            begin
                // Strobe falls after select: this edge starts the write
                s_d.we_n = 1'b0;
                // Pulse covers both the width and the data setup figure
                s_d.cnt = (`WRITE_PULSE_CYC > `DATA_SETUP_CYC) ?
                    `PHASE_CNT_W'(`WRITE_PULSE_CYC) : `PHASE_CNT_W'(`DATA_SETUP_CYC);
                s_d.state = ST_WPULS;
            end
            ST_WPULS:
            begin
                // Address and data held unchanged throughout the pulse
                if (s_q.cnt == '0)
                begin
                    // Strobe rises first and ends the write, select still low
                    s_d.we_n = 1'b1;
                    s_d.cnt = `PHASE_CNT_W'(`RECOVERY_CYC);
                    s_d.state = ST_WREC;
                end
            end
            ST_WREC:
            begin
                // Recovery count keeps the strobe high before the next select
                // Data held a cycle past the strobe rise, then released
                s_d.cs_n = 1'b1;
                s_d.doe = 1'b0;
                if (s_q.cnt == '0)
                begin
                    s_d.state = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                // Single idle cycle with everything deselected
                s_d.ready = !guard_blocked;
                s_d.state = ST_IDLE;
            end
            default:
            begin
                // Unreachable with one-hot codes; parks the pins idle
                s_d.state = ST_IDLE;
                s_d.cs_n = 1'b1;
                s_d.we_n = 1'b1;
                s_d.oe_n = 1'b1;
                s_d.doe = 1'b0;
                s_d.ready = 1'b0;
            end
        endcase
    end

    // Reset never reaches the memory array, only the pin drivers
    // Pins idle high and undriven during reset; memory keeps its contents
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q <= '{state: ST_IDLE, cnt: '0, addr: '0, cs_n: 1'b1, we_n: 1'b1,
                     oe_n: 1'b1, dout: '0, doe: 1'b0, ready: 1'b0,
                     rsp_valid: 1'b0, rdata: '0, blocked: 1'b1};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // No glue between flops and pins, so pin timing is exactly the walk
    // Outputs straight from the state flops
    assign req_ready_o = s_q.ready;
    assign rsp_valid_o = s_q.rsp_valid;
    assign rsp_rdata_o = s_q.rdata;
    assign blocked_o = s_q.blocked;
    assign addr_in_o = s_q.addr;
    assign chip_sel_n_o = s_q.cs_n;
    assign write_strobe_n_o = s_q.we_n;
    assign out_en_n_o = s_q.oe_n;
    assign data_io_o = s_q.dout;
    assign data_io_oe_o = s_q.doe;

endmodule

// File: testbench/sram_ctl_checker.sv
/* Pin timing checker for sram_ctl.
   Bound from tb; sees only the top ports, one clock domain. */
`timescale 1ns/100ps
module sram_ctl_checker (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic protect_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic [10:0] addr_in_o,
    input wire logic chip_sel_n_o,
    input wire logic write_strobe_n_o,
    input wire logic out_en_n_o,
    input wire logic [7:0] data_io_o,
    input wire logic data_io_oe_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // Enable low only in reads, so the data bus never fights
    a_read_quiet: assert property (!out_en_n_o |-> write_strobe_n_o && !data_io_oe_o)
        else $error("enable low while writing");
    a_strobe_in_select: assert property (!write_strobe_n_o |-> !chip_sel_n_o && out_en_n_o)
        else $error("strobe low outside select");
    a_addr_hold: assert property (!chip_sel_n_o && $past(!chip_sel_n_o) |-> $stable(addr_in_o))
        else $error("address moved during access");
    a_pulse_width: assert property ($fell(write_strobe_n_o) |-> !write_strobe_n_o [*4] ##1 write_strobe_n_o)
        else $error("strobe pulse not four cycles");
    // Data must stand two cycles (50 ns) before the strobe rises
    a_data_setup: assert property ($rose(write_strobe_n_o) |->
        data_io_oe_o && $past(data_io_oe_o, 2) && data_io_o == $past(data_io_o, 2))
        else $error("write data setup too short");
    a_strobe_first: assert property ($rose(chip_sel_n_o) |-> write_strobe_n_o && $past(write_strobe_n_o))
        else $error("select rose before strobe");
    a_read_latency: assert property ($fell(out_en_n_o) |-> !rsp_valid_o [*5] ##1 rsp_valid_o)
        else $error("read response not at sixth cycle");
    a_protect_refuse: assert property (protect_i |-> ##2 !req_ready_o)
        else $error("ready while protected");
endmodule

// File: testbench/nv_mem_model.sv
/* Behavioural model of the 2k x 8 battery-backed memory.
   Assumes active-low controls from the controller; no clock. */
`timescale 1ns/100ps
module nv_mem_model #(
    parameter int ACC_NS = 90
) (
    input wire logic [10:0] addr_i,
    input wire logic cs_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic protect_i,
    input wire logic [7:0] din_i,
    output logic [7:0] dq_o
);
    logic [7:0] mem [0:2047]; // Never cleared by any reset
    logic armed; // Both controls low, write in progress
    wire rd_en = !cs_n_i && !oe_n_i && we_n_i && !protect_i;
    // Preload a known pattern so fresh reads are checkable
    initial
    begin
        armed = 1'b0;
        for (int i = 0; i < 2048; i++) mem[i] = 8'(i * 7);
    end
    // Later falling edge starts the write
    always @(negedge cs_n_i or negedge we_n_i) armed = !cs_n_i && !we_n_i && !protect_i;
    // First rising edge ends it and commits the data
    always @(posedge cs_n_i or posedge we_n_i)
    begin
        if (armed && !protect_i) mem[addr_i] = din_i;
        armed = 1'b0;
    end
    // Released bus shows a non-matching pattern, not the last value
    assign #(ACC_NS) dq_o = rd_en ? mem[addr_i] : ~mem[addr_i] ^ 8'h5a;
endmodule

// File: testbench/tb.sv
/* Self-checking bench for sram_ctl against the memory model.
   Assumes the logic/ files are compiled first. */
`timescale 1ns/100ps
module tb;
    localparam int PROT = 20; // Shortened guard wait
    logic sys_clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0, protect_i = 1'b0;
    logic [10:0] req_addr_i = 11'h000, addr_in_o;
    logic [7:0] req_wdata_i = 8'h00, rsp_rdata_o, data_io_o, dq, q;
    logic req_ready_o, rsp_valid_o, blocked_o, chip_sel_n_o, write_strobe_n_o, out_en_n_o, data_io_oe_o;
    wire [7:0] data_io = data_io_oe_o ? data_io_o : dq; // Resolved data bus
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    sram_ctl #(.PROTECT_CYCLES(PROT)) dut (.sys_clk_i, .rst_i, .req_valid_i, .req_write_i, .req_addr_i,
        .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .blocked_o, .protect_i, .addr_in_o,
        .chip_sel_n_o, .write_strobe_n_o, .out_en_n_o, .data_io_i(data_io), .data_io_o, .data_io_oe_o);
    nv_mem_model partner (.addr_i(addr_in_o), .cs_n_i(chip_sel_n_o), .we_n_i(write_strobe_n_o),
        .oe_n_i(out_en_n_o), .protect_i, .din_i(data_io), .dq_o(dq));
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One request held until taken; a read then waits for its pulse
    task op(input logic wr, input logic [10:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req_valid_i = 1'b1;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        while (req_ready_o !== 1'b1 && n < 100)
        begin
            @(posedge sys_clk_i) #1;
            n++;
        end
        check("ready", {7'h00, req_ready_o}, 8'h01);
        @(posedge sys_clk_i) #1;
        req_valid_i = 1'b0;
        n = 0;
        while (!wr && rsp_valid_o !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk_i) #1;
            n++;
        end
        if (!wr) check("rsp_valid", {7'h00, rsp_valid_o}, 8'h01);
        q = rsp_rdata_o;
        // Let an edge pass so a following call never re-raises valid at once
        @(posedge sys_clk_i) #1;
    endtask
    task rd(input logic [10:0] a, input logic [7:0] exp);
        op(1'b0, a, 8'h00);
        check("rdata", q, exp);
    endtask
    // Writes at both address ends, back to back, then readback
    task t_rw;
        rd(11'h003, 8'h15);
        op(1'b1, 11'h000, 8'ha5);
        op(1'b1, 11'h7ff, 8'h3c);
        op(1'b1, 11'h155, 8'h5a);
        rd(11'h000, 8'ha5);
        rd(11'h7ff, 8'h3c);
        rd(11'h155, 8'h5a);
        rd(11'h2aa, 8'ha6);
        $display("test rw done");
    endtask
    // Write attempted while protected must be ignored
    task t_prot;
        int n;
        protect_i = 1'b1;
        repeat (3) @(posedge sys_clk_i) #1;
        check("ready", {7'h00, req_ready_o}, 8'h00);
        check("blocked", {7'h00, blocked_o}, 8'h01);
        req_valid_i = 1'b1;
        req_write_i = 1'b1;
        req_addr_i = 11'h155;
        req_wdata_i = 8'hee;
        repeat (2) @(posedge sys_clk_i) #1;
        req_valid_i = 1'b0;
        protect_i = 1'b0;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 100)
        begin
            @(posedge sys_clk_i) #1;
            n++;
        end
        check("wait", 8'(n >= PROT - 1 && n <= PROT + 3), 8'h01);
        check("unblocked", {7'h00, blocked_o}, 8'h00);
        rd(11'h155, 8'h5a);
        $display("test protect done");
    endtask
    // Contents survive a reset in mid-run
    task t_reset;
        rst_i = 1'b1;
        repeat (3) @(posedge sys_clk_i) #1;
        check("rst blocked", {7'h00, blocked_o}, 8'h01);
        rst_i = 1'b0;
        rd(11'h7ff, 8'h3c);
        $display("test reset done");
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (num_checks > 0 && n_mismatch == 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard, far above the hundred or so cycles needed
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            complete_run;
        end
    end
    initial
    begin
        repeat (3) @(posedge sys_clk_i) #1;
        rst_i = 1'b0;
        t_rw;
        t_prot;
        t_reset;
        complete_run;
    end
endmodule
bind sram_ctl sram_ctl_checker chk (.sys_clk_i, .rst_i, .protect_i, .req_ready_o, .rsp_valid_o, .addr_in_o,
    .chip_sel_n_o, .write_strobe_n_o, .out_en_n_o, .data_io_o, .data_io_oe_o);
